// file: pkg/corr_wake_map.vh
// Register map, field positions, reset values and timing of the threshold/wake bank
`ifndef CORR_WAKE_MAP_VH
`define CORR_WAKE_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_ZERO_LIMIT  8'h19
`define ADDR_ONE_LIMIT   8'h1A
`define ADDR_WAKE_EN     8'h1C
`define ADDR_WAKE_STAT   8'h1D
`define ADDR_ANALOG      8'h20

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_ZERO_LIMIT   7'h08
`define RST_ONE_LIMIT    7'h38
`define RST_WAKE_EN      1'h0
`define RST_WAKE_STAT    1'h1
`define RST_ANALOG       8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define LIMIT_MSB        6
`define WAKE_BIT         0
`define AN_RESET         0
`define AN_AMP_INV       1
`define AN_AMP_OE        2
`define AN_ID_READ       5
`define AN_AGC_OFF       6

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS    50
`define WAKE_READY_NS    1000
`define WAKE_READY_CYC   ((`WAKE_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: src/pin_sync_3ff.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync_3ff #(
    parameter RESET_LEVEL = 1'b1        // Level shown during reset
) (
    input  wire mclk,                   // System clock
    input  wire rst,                    // Async reset, active high
    input  wire pinIn,                  // Raw pin level
    output reg  pinLevel                // Filtered, synchronous level
);

    reg stage1;                         // First stage, read only by stage2
    reg stage2;                         // Second stage
    reg stage3;                         // Third stage

    // ****************************************************************
    // Shift chain; accept a change once stage2 and stage3 agree
    // ****************************************************************
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1   <= RESET_LEVEL;
            stage2   <= RESET_LEVEL;
            stage3   <= RESET_LEVEL;
            pinLevel <= RESET_LEVEL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin // Stable for two samples
                pinLevel <= stage3;
            end
        end
    end

endmodule // pin_sync_3ff
`default_nettype wire

// file: src/corr_decide.v
// Correlator bit decision against the low and high limits
`timescale 1ns/1ps
`default_nettype none

module corr_decide #(
    parameter CHIPS = 64                // Full code length in chips
) (
    input  wire             mclk,       // System clock
    input  wire             rst,        // Async reset, active high
    input  wire             chipStrobe, // One bit worth of chips ready
    input  wire [CHIPS-1:0] rxChips,    // Received chips
    input  wire [CHIPS-1:0] pnCode,     // Spreading code
    input  wire             halfCode,   // 1: use low half only
    input  wire [6:0]       lowLimit,   // Zero decision bound
    input  wire [6:0]       highLimit,  // One decision bound
    output reg              bitValid,   // Pulse: decision made
    output reg              bitValue,   // Decided bit
    output reg              bitErased,  // Pulse: count between bounds
    output reg  [6:0]       matchCount  // Last match count
);

    wire [CHIPS-1:0] agree;             // Chip equals code chip
    wire [CHIPS-1:0] used;              // Chips that take part
    wire [6:0]       count;             // Matches this bit

    // Count set bits of a chip vector
    function [6:0] popCount;
        input [CHIPS-1:0] v;
        integer i;
        begin
            popCount = 7'h00;
            for (i = 0; i < CHIPS; i = i + 1) begin
                popCount = popCount + {6'h00, v[i]};
            end
        end
    endfunction

    // ****************************************************************
    // Match count: inverse code gives 0, exact code gives length
    // ****************************************************************
    assign agree = ~(rxChips ^ pnCode);
    assign used  = halfCode ? {{(CHIPS/2){1'b0}}, {(CHIPS/2){1'b1}}}
                            : {CHIPS{1'b1}};
    assign count = popCount(agree & used);

    // ****************************************************************
    // Decision using both limits for every bit
    // ****************************************************************
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            bitValid   <= 1'b0;
            bitValue   <= 1'b0;
            bitErased  <= 1'b0;
            matchCount <= 7'h00;
        end else begin
            bitValid  <= 1'b0;
            bitErased <= 1'b0;
            if (chipStrobe) begin
                matchCount <= count;
                if (count >= highLimit) begin
                    bitValid <= 1'b1;
                    bitValue <= 1'b1;
                end else if (count <= lowLimit) begin
                    bitValid <= 1'b1;
                    bitValue <= 1'b0;
                end else begin
                    bitErased <= 1'b1;
                end
            end
        end
    end

endmodule // corr_decide
`default_nettype wire

// file: src/correlator_threshold_wake_regs.v
// Threshold, wake and analog control register bank of the radio modem
`timescale 1ns/1ps
`default_nettype none
`include "corr_wake_map.vh"

module correlator_threshold_wake_regs #(
    parameter CHIPS      = 64,              // Full code length
    parameter READY_CYC  = `WAKE_READY_CYC  // Cycles from release to ready
) (
    input  wire             mclk,           // System clock, 20 MHz
    input  wire             rst,            // Async reset, active high
    input  wire [7:0]       regAddr,        // Register address
    input  wire [7:0]       regWdata,       // Write data
    input  wire             regWrite,       // Write strobe, one cycle
    input  wire             regRead,        // Read strobe, one cycle
    output reg  [7:0]       regRdata,       // Read data, registered
    output reg              regRvalid,      // Read data valid pulse
    input  wire             powerDownPinN,  // Power-down pin, active low
    input  wire             txActive,       // Transmitter on
    input  wire             chipStrobe,     // Chips of one bit ready
    input  wire [CHIPS-1:0] rxChips,        // Received chips
    input  wire [CHIPS-1:0] pnCode,         // Spreading code
    input  wire             halfCode,       // 32-chip mode
    output wire             bitValid,       // Decision pulse
    output wire             bitValue,       // Decided bit
    output wire             bitErased,      // No valid bit pulse
    output wire [6:0]       matchCount,     // Last match count
    output reg              wakeIrq,        // Wake interrupt, active high
    output reg              hostReady,      // Serial access accepted
    output reg              extAmpControlOut, // External amplifier line
    output reg              idReadEnable,   // Identifier block powered
    output reg              autoGainLoopOff,// Gain loop disabled
    output reg              deviceReset     // Self-clearing reset pulse
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam [2:0] ST_DOWN  = 3'b001;     // Held in power-down
    localparam [2:0] ST_WAIT  = 3'b010;     // Released, warming up
    localparam [2:0] ST_AWAKE = 3'b100;     // Ready for serial traffic
    localparam [7:0] AN_DEF   = `RST_ANALOG; // Analog defaults

    reg  [6:0]  zeroLimit;                  // Zero decision bound
    reg  [6:0]  oneLimit;                   // One decision bound
    reg         wakeEnable;                 // Wake interrupt enable
    reg         wakeFlag;                   // Wake pending flag
    reg         ampInvert;                  // Amplifier polarity
    reg         ampOutputEnable;            // Amplifier line enable
    reg  [2:0]  wakeState;                  // Wake sequencer state
    reg  [2:0]  next_wakeState;             // Its next value
    reg  [15:0] readyCount;                 // Warm-up counter
    reg  [15:0] next_readyCount;            // Its next value
    reg         wakeEvent;                  // Wake condition pulse
    reg         next_wakeEvent;             // Its next value
    reg  [7:0]  next_rdata;                 // Read mux result
    wire        pinLevel;                   // Synchronised pin level
    wire        wrHit;                      // Any write this cycle outside a soft reset
    wire        rdStatus;                   // Status read this cycle
    wire        next_wakeFlag;              // Flag next value

    // Match the address against one register
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // ****************************************************************
    // Power-down pin synchroniser
    // ****************************************************************
    pin_sync_3ff #(
        .RESET_LEVEL (1'b1)
    ) u_pinSync (
        .mclk     (mclk),
        .rst      (rst),
        .pinIn    (powerDownPinN),
        .pinLevel (pinLevel)
    );

    // ****************************************************************
    // Wake sequencer
    // ****************************************************************
    // Next state: release of the pin, then warm-up, then wake
    always @* begin
        next_wakeState  = wakeState;
        next_readyCount = readyCount;
        next_wakeEvent  = 1'b0;
        case (wakeState)
            ST_DOWN: begin
                next_readyCount = 16'h0000;
                if (pinLevel) begin         // Pin released
                    next_wakeState = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!pinLevel) begin        // Asserted again
                    next_wakeState = ST_DOWN;
                end else if (readyCount >= READY_CYC[15:0] - 16'h0001) begin
                    next_wakeState = ST_AWAKE;
                    next_wakeEvent = 1'b1;
                end else begin
                    next_readyCount = readyCount + 16'h0001;
                end
            end
            ST_AWAKE: begin
                if (!pinLevel) begin        // Back to power-down
                    next_wakeState = ST_DOWN;
                end
            end
            default: begin
                next_wakeState = ST_DOWN;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wakeState  <= ST_AWAKE;
            readyCount <= 16'h0000;
            wakeEvent  <= 1'b0;
            hostReady  <= 1'b0;
        end else begin
            wakeState  <= next_wakeState;
            readyCount <= next_readyCount;
            wakeEvent  <= next_wakeEvent;
            hostReady  <= (next_wakeState == ST_AWAKE);
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    assign wrHit    = regWrite && !deviceReset;
    assign rdStatus = regRead && hit(regAddr, `ADDR_WAKE_STAT);

    // Set beats the read clear in the same cycle
    assign next_wakeFlag = wakeEvent | (wakeFlag & ~rdStatus);

    // Writable fields; unused bits are not stored
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            zeroLimit       <= `RST_ZERO_LIMIT;
            oneLimit        <= `RST_ONE_LIMIT;
            wakeEnable      <= `RST_WAKE_EN;
            ampInvert       <= AN_DEF[`AN_AMP_INV];
            ampOutputEnable <= AN_DEF[`AN_AMP_OE];
            idReadEnable    <= AN_DEF[`AN_ID_READ];
            autoGainLoopOff <= AN_DEF[`AN_AGC_OFF];
            deviceReset     <= 1'b0;
        end else if (deviceReset) begin
            zeroLimit       <= `RST_ZERO_LIMIT;
            oneLimit        <= `RST_ONE_LIMIT;
            wakeEnable      <= `RST_WAKE_EN;
            ampInvert       <= AN_DEF[`AN_AMP_INV];
            ampOutputEnable <= AN_DEF[`AN_AMP_OE];
            idReadEnable    <= AN_DEF[`AN_ID_READ];
            autoGainLoopOff <= AN_DEF[`AN_AGC_OFF];
            deviceReset     <= 1'b0;
        end else if (wrHit) begin
            if (hit(regAddr, `ADDR_ZERO_LIMIT)) begin
                zeroLimit <= regWdata[`LIMIT_MSB:0];
            end
            if (hit(regAddr, `ADDR_ONE_LIMIT)) begin
                oneLimit <= regWdata[`LIMIT_MSB:0];
            end
            if (hit(regAddr, `ADDR_WAKE_EN)) begin
                wakeEnable <= regWdata[`WAKE_BIT];
            end
            if (hit(regAddr, `ADDR_ANALOG)) begin
                ampInvert       <= regWdata[`AN_AMP_INV];
                ampOutputEnable <= regWdata[`AN_AMP_OE];
                idReadEnable    <= regWdata[`AN_ID_READ];
                autoGainLoopOff <= regWdata[`AN_AGC_OFF];
                deviceReset     <= regWdata[`AN_RESET];
            end
        end
    end

    // Wake pending flag; only the soft reset write reaches it, setting it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wakeFlag <= `RST_WAKE_STAT;
        end else if (deviceReset) begin
            wakeFlag <= `RST_WAKE_STAT | wakeEvent;
        end else begin
            wakeFlag <= next_wakeFlag;
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Read mux; reserved bits and unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        case (regAddr)
            `ADDR_ZERO_LIMIT: next_rdata = {1'b0, zeroLimit};
            `ADDR_ONE_LIMIT:  next_rdata = {1'b0, oneLimit};
            `ADDR_WAKE_EN:    next_rdata = {7'h00, wakeEnable};
            `ADDR_WAKE_STAT:  next_rdata = {7'h00, wakeFlag};
            `ADDR_ANALOG:     next_rdata = {1'b0, autoGainLoopOff,
                                            idReadEnable, 2'h0,
                                            ampOutputEnable, ampInvert,
                                            1'b0};
            default:          next_rdata = 8'h00;
        endcase
    end

    // Capture read data the edge after the strobe
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata  <= 8'h00;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= next_rdata;
            end
        end
    end

    // ****************************************************************
    // Outputs: interrupt and amplifier line
    // ****************************************************************
    // Interrupt and amplifier line, both registered
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wakeIrq          <= 1'b0;
            extAmpControlOut <= 1'b0;
        end else begin
            wakeIrq <= wakeEnable & wakeFlag;
            if (ampOutputEnable) begin
                extAmpControlOut <= txActive ^ ampInvert;
            end else begin
                extAmpControlOut <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Correlator decision
    // ****************************************************************
    corr_decide #(
        .CHIPS (CHIPS)
    ) u_decide (
        .mclk       (mclk),
        .rst        (rst),
        .chipStrobe (chipStrobe),
        .rxChips    (rxChips),
        .pnCode     (pnCode),
        .halfCode   (halfCode),
        .lowLimit   (zeroLimit),
        .highLimit  (oneLimit),
        .bitValid   (bitValid),
        .bitValue   (bitValue),
        .bitErased  (bitErased),
        .matchCount (matchCount)
    );

endmodule // correlator_threshold_wake_regs
`default_nettype wire

// file: tb/corr_wake_assertions.sv
// Concurrent checks on the ports of the threshold and wake register bank
`timescale 1ns/1ps
`default_nettype none
`include "corr_wake_map.vh"

module corr_wake_assertions #(
    parameter CHIPS = 64                        // Code length in chips
) (
    input wire logic             mclk,          // System clock
    input wire logic             rst,           // Async reset, active high
    input wire logic [7:0]       regAddr,       // Register address
    input wire logic [7:0]       regWdata,      // Write data
    input wire logic             regWrite,      // Write strobe
    input wire logic             regRead,       // Read strobe
    input wire logic             regRvalid,     // Read data valid
    input wire logic             powerDownPinN, // Power-down pin, active low
    input wire logic             chipStrobe,    // Chips of one bit ready
    input wire logic [CHIPS-1:0] rxChips,       // Received chips
    input wire logic [CHIPS-1:0] pnCode,        // Spreading code
    input wire logic             halfCode,      // 32-chip mode
    input wire logic             bitValid,      // Decision pulse
    input wire logic             bitErased,     // No valid bit pulse
    input wire logic [6:0]       matchCount,    // Last match count
    input wire logic             hostReady,     // Serial access accepted
    input wire logic             deviceReset    // Soft reset pulse
);
    // ****************************************************************
    // Common clock, reset and soft reset request
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire softReq = regWrite && (regAddr == `ADDR_ANALOG) && regWdata[0]; // Reset bit write

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_read_answer; regRead |=> regRvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_quiet; !regRead |=> !regRvalid; endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("stray read valid");
    property p_soft_cause; softReq && !deviceReset |=> deviceReset; endproperty
    a_soft_cause: assert property (p_soft_cause) else $error("soft reset missing");
    property p_soft_pulse; deviceReset |-> $past(softReq) ##1 !deviceReset; endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse bad");
    property p_decide; chipStrobe |=> (bitValid != bitErased); endproperty
    a_decide: assert property (p_decide) else $error("no single decision");
    property p_idle; !chipStrobe |=> !bitValid && !bitErased; endproperty
    a_idle: assert property (p_idle) else $error("decision without strobe");
    property p_zero; chipStrobe && !halfCode && rxChips == ~pnCode |=> matchCount == 7'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("inverse code count not zero");
    property p_one; chipStrobe && !halfCode && rxChips == pnCode |=> matchCount == 7'h40;
    endproperty
    a_one: assert property (p_one) else $error("full code count not 64");
    property p_half;
        chipStrobe && halfCode && rxChips[31:0] == pnCode[31:0] |=> matchCount == 7'h20;
    endproperty
    a_half: assert property (p_half) else $error("half code count not 32");
    property p_down; !powerDownPinN [*8] |=> !hostReady; endproperty
    a_down: assert property (p_down) else $error("ready while powered down");

    // ****************************************************************
    // Coverage of main scenarios
    // ****************************************************************
    c_soft: cover property (deviceReset);
    c_erased: cover property (bitErased);
    c_wake: cover property (!hostReady ##1 hostReady);
endmodule // corr_wake_assertions
`default_nettype wire

// file: tb/host_model.sv
// Host controller model issuing register strobes
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic       mclk,      // System clock
    output var  logic [7:0] regAddr,   // Register address
    output var  logic [7:0] regWdata,  // Write data
    output var  logic       regWrite,  // Write strobe
    output var  logic       regRead,   // Read strobe
    input  wire logic [7:0] regRdata,  // Read data
    input  wire logic       regRvalid  // Read data valid
);
    // Idle bus at time zero
    initial begin
        regAddr = 8'hFF;
        regWdata = 8'hFF;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // One-cycle write strobe, then address and data turned over
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    // One-cycle read strobe, data taken while valid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRvalid ? regRdata : 8'hXX;
    endtask
endmodule // host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the threshold and wake register bank
`timescale 1ns/1ps
`default_nettype none
`include "corr_wake_map.vh"

module tb;
    localparam logic [63:0] CODE = 64'hA5C30F963C5AE187; // Test spreading code
    logic        mclk = 1'b0;           // System clock
    logic        rst = 1'b1;            // Reset
    logic [7:0]  regAddr, regWdata;     // Host address and data
    logic        regWrite, regRead;     // Host strobes
    logic [7:0]  regRdata;              // Read data
    logic        regRvalid;             // Read valid
    logic        powerDownPinN = 1'b1;  // Power-down pin
    logic        txActive = 1'b0;       // Transmitter on
    logic        chipStrobe = 1'b0;     // Chips ready
    logic        halfCode = 1'b0;       // Half code mode
    logic [63:0] rxChips = 64'h0;       // Received chips
    logic [63:0] pnCode = CODE;         // Spreading code
    logic        bitValid, bitValue, bitErased; // Decision outputs
    logic [6:0]  matchCount;            // Match count
    logic        wakeIrq, hostReady, extAmpControlOut; // Wake and amp
    logic        idReadEnable, autoGainLoopOff, deviceReset; // Analog outputs
    int          errCount = 0;          // Mismatches
    int          samplesChecked = 0;    // Comparisons
    int          cycles = 0;            // Timeout counter
    int          i;                     // Wait loop index

    always #25 mclk = ~mclk;

    correlator_threshold_wake_regs #(.CHIPS(64), .READY_CYC(4)) i_correlator_threshold_wake_regs (
        .mclk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .regRvalid,
        .powerDownPinN, .txActive, .chipStrobe, .rxChips, .pnCode, .halfCode, .bitValid,
        .bitValue, .bitErased, .matchCount, .wakeIrq, .hostReady, .extAmpControlOut,
        .idReadEnable, .autoGainLoopOff, .deviceReset);
    host_model i_host_model (.mclk, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .regRvalid);

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host_model.rd(a, d);
        chk(d, exp, "register read");
    endtask
    // One strobe; kind 0 zero, 1 one, 2/3 erased holding 0/1
    task automatic corr(input logic [63:0] rx, input logic h, input logic [6:0] cnt,
                        input logic [1:0] kind);
        @(posedge mclk);
        chipStrobe <= 1'b1;
        rxChips <= rx;
        halfCode <= h;
        @(posedge mclk);
        chipStrobe <= 1'b0;
        #1;
        chk({1'b0, matchCount}, {1'b0, cnt}, "match count");
        chk({5'h0, bitErased, bitValid, bitValue},
            kind[1] ? {7'h02, kind[0]} : {7'h01, kind[0]}, "decision");
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount++;
            summarize;
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdChk(`ADDR_ZERO_LIMIT, 8'h08);
        rdChk(`ADDR_ONE_LIMIT, 8'h38);
        rdChk(`ADDR_WAKE_EN, 8'h00);
        rdChk(`ADDR_WAKE_STAT, 8'h01);
        rdChk(`ADDR_WAKE_STAT, 8'h00);
        rdChk(`ADDR_ANALOG, 8'h00);
        rdChk(8'h30, 8'h00);
        $display("Test reset values done");
        i_host_model.wr(`ADDR_ZERO_LIMIT, 8'h05);
        i_host_model.wr(`ADDR_ONE_LIMIT, 8'h3C);
        i_host_model.wr(`ADDR_WAKE_EN, 8'h01);
        i_host_model.wr(`ADDR_WAKE_STAT, 8'hFF);
        rdChk(`ADDR_ZERO_LIMIT, 8'h05);
        rdChk(`ADDR_ONE_LIMIT, 8'h3C);
        rdChk(`ADDR_WAKE_EN, 8'h01);
        rdChk(`ADDR_WAKE_STAT, 8'h00);
        $display("Test register access done");
        corr(CODE, 1'b0, 7'd64, 2'd1);
        corr(~CODE, 1'b0, 7'd0, 2'd0);
        corr(CODE ^ 64'hF, 1'b0, 7'd60, 2'd1);
        corr(CODE ^ 64'h1F, 1'b0, 7'd59, 2'd3);
        corr(~CODE ^ 64'h1F, 1'b0, 7'd5, 2'd0);
        corr(~CODE ^ 64'h3F, 1'b0, 7'd6, 2'd2);
        corr(CODE, 1'b1, 7'd32, 2'd2);
        $display("Test correlator done");
        @(posedge mclk) powerDownPinN <= 1'b0;
        repeat (20) @(posedge mclk);
        #1 chk({7'h0, hostReady}, 8'h00, "ready while down");
        @(posedge mclk) powerDownPinN <= 1'b1;
        for (i = 0; i < 40 && hostReady !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        repeat (3) @(posedge mclk);
        #1 chk({6'h0, hostReady, wakeIrq}, 8'h03, "wake event");
        rdChk(`ADDR_WAKE_STAT, 8'h01);
        repeat (3) @(posedge mclk);
        #1 chk({7'h0, wakeIrq}, 8'h00, "wake cleared by read");
        $display("Test wake done");
        i_host_model.wr(`ADDR_ANALOG, 8'h04);
        @(posedge mclk) txActive <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, extAmpControlOut}, 8'h01, "amp active high");
        i_host_model.wr(`ADDR_ANALOG, 8'h06);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, extAmpControlOut}, 8'h00, "amp active low");
        @(posedge mclk) txActive <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, extAmpControlOut}, 8'h01, "amp idle inverted");
        i_host_model.wr(`ADDR_ANALOG, 8'h66);
        rdChk(`ADDR_ANALOG, 8'h66);
        chk({6'h0, idReadEnable, autoGainLoopOff}, 8'h03, "analog outputs");
        i_host_model.wr(`ADDR_ANALOG, 8'h07);
        repeat (2) @(posedge mclk);
        rdChk(`ADDR_ZERO_LIMIT, 8'h08);
        rdChk(`ADDR_WAKE_STAT, 8'h01);
        rdChk(`ADDR_ANALOG, 8'h00);
        $display("Test analog and soft reset done");
        summarize;
    end
endmodule // tb

bind correlator_threshold_wake_regs corr_wake_assertions #(.CHIPS(CHIPS)) i_corr_wake_assertions (
    .mclk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRvalid, .powerDownPinN,
    .chipStrobe, .rxChips, .pnCode, .halfCode, .bitValid, .bitErased, .matchCount,
    .hostReady, .deviceReset);
`default_nettype wire
